// file: src/mlmc_pkg.sv
package mlmc_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int T_CARRIER_ON_MS = 10;
  localparam int T_CARRIER_OFF_MS = 5;
  localparam int T_CMD_SPACE_MS = 125;
  localparam int CARRIER_ON_CYC = CLK_HZ / 1000 * T_CARRIER_ON_MS;
  localparam int CARRIER_OFF_CYC = CLK_HZ / 1000 * T_CARRIER_OFF_MS;
  localparam int CMD_SPACE_CYC = CLK_HZ / 1000 * T_CMD_SPACE_MS;
  localparam int T_LOSS_UNIT_MS = 100;
  localparam int LOSS_UNIT_CYC = CLK_HZ / 1000 * T_LOSS_UNIT_MS;
  localparam int CNT_W = 21;
  typedef logic [CNT_W-1:0] mlmc_cnt_t;

  // Register numbers as used on the command port
  localparam logic [7:0] REG_CARRIER_LOSS = 8'h0a;
  localparam logic [7:0] REG_RETRAIN_INIT = 8'h1a;
  localparam logic [7:0] REG_RETRAIN_THR = 8'h46;
  localparam logic [7:0] REG_CMD_SPACING = 8'h49;
  localparam logic [7:0] REG_CALLER_ID = 8'h5f;
  localparam logic [7:0] REG_COUNTRY = 8'h63;
  localparam logic [7:0] REG_CALL_OPT = 8'h6e;
  localparam logic [7:0] REG_ANS_TONE = 8'h78;
  localparam logic [7:0] REG_RING_THR = 8'h7b;

  localparam int SPACING_BIT = 5;
  localparam int RETRAIN_INIT_BIT = 2;
  localparam int TYPE2_CID_BIT = 3;
  localparam int RING_NOFREQ_BIT = 7;
  localparam logic [7:0] CID_SNOOP_VAL = 8'h99;
  localparam logic [7:0] LOSS_NEVER = 8'hff;
  localparam logic [7:0] ANS_TONE_MASK = 8'h37;

  localparam logic [7:0] RST_ANS = 8'h35;
  localparam logic [7:0] RST_RING = 8'h00;
  localparam logic [7:0] RST_LOSS = 8'h0e;
  localparam logic [7:0] RST_SPACING = 8'h20;
  localparam logic [7:0] RST_RETRAIN_INIT = 8'h00;
  localparam logic [7:0] RST_RETRAIN_THR = 8'h20;
  localparam logic [7:0] RST_CALL_OPT = 8'h00;
  localparam logic [7:0] RST_CID = 8'h00;
  localparam logic [7:0] PROF_US = 8'h01;
  localparam logic [7:0] PROF_OTHER_RING = 8'h07;

  // Result text, index 0 leaves first
  localparam logic [3:0][7:0] OK_MSG = {8'h0a, 8'h0d, 8'h4b, 8'h4f};

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_SREG_WR = 4'h1,
    CMD_SREG_RD = 4'h2,
    CMD_GATED_HALF_DUPLEX = 4'h3,
    CMD_OTHER_MODULATION = 4'h4,
    CMD_FIXED_LINK_MODE = 4'h5,
    CMD_RAW_CARRIER = 4'h6,
    CMD_QUALIFIED_CARRIER = 4'h7,
    CMD_HANGUP_ON_TOGGLE = 4'h8,
    CMD_RETRAIN_RESPONSE = 4'h9,
    CMD_DIAL = 4'ha,
    CMD_ANSWER = 4'hb,
    CMD_HANGUP = 4'hc,
    CMD_FACTORY = 4'hd
  } mlmc_cmd_e;

  typedef enum logic [3:0] {
    LK_IDLE = 4'b0001,
    LK_TRAIN = 4'b0010,
    LK_DATA = 4'b0100,
    LK_HANGUP = 4'b1000
  } mlmc_link_e;

  typedef enum logic [3:0] {
    HD_OFF = 4'b0001,
    HD_ON_DLY = 4'b0010,
    HD_ON = 4'b0100,
    HD_OFF_DLY = 4'b1000
  } mlmc_hd_e;

  typedef enum logic [2:0] {
    CID_IDLE = 3'b001,
    CID_SEND_D = 3'b010,
    CID_RX = 3'b100
  } mlmc_cid_e;
endpackage

// file: src/mlmc_fifo.sv
`timescale 1ns/1ps
module mlmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input logic clk,
  input logic rst,
  input logic in_valid,
  input logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input logic out_ready,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } mlmc_fifo_s;
  mlmc_fifo_s f_q, f_d;
  logic push, pop;

  assign in_ready = (f_q.cnt != CW'(DEPTH));
  assign push = in_valid && in_ready;
  // Output word sits in a register so the consumer sees flop outputs
  assign pop = (f_q.cnt != '0) && (!f_q.ov || out_ready);
  assign out_valid = f_q.ov;
  assign out_data = f_q.od;
  assign empty = (f_q.cnt == '0) && !f_q.ov;

  always_comb begin
    f_d = f_q;
    if (out_ready) begin
      f_d.ov = 1'b0;
    end
    if (pop) begin
      f_d.od = f_q.mem[f_q.rd];
      f_d.ov = 1'b1;
      f_d.rd = (f_q.rd == AW'(DEPTH - 1)) ? '0 : f_q.rd + 1'b1;
    end
    if (push) begin
      f_d.mem[f_q.wr] = in_data;
      f_d.wr = (f_q.wr == AW'(DEPTH - 1)) ? '0 : f_q.wr + 1'b1;
    end
    f_d.cnt = f_q.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end
endmodule

// file: src/mlmc_top.sv
`timescale 1ns/1ps
module mlmc_top
  import mlmc_pkg::*;
#(
  parameter int ON_CYC = CARRIER_ON_CYC,
  parameter int OFF_CYC = CARRIER_OFF_CYC,
  parameter int SPACE_CYC = CMD_SPACE_CYC,
  parameter int LOSS_CYC = LOSS_UNIT_CYC,
  parameter int FIFO_W = 8,
  parameter int FIFO_DEPTH = 32
) (
  input logic clk,
  input logic rst,
  input logic cmd_valid,
  input logic [3:0] cmd_code,
  input logic [7:0] cmd_addr,
  input logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic [7:0] sreg_rdata,
  output logic sreg_rvalid,
  input logic rts,
  output logic cts,
  input logic dtr,
  output logic tx_carrier,
  output logic search_remote,
  output logic train_start,
  input logic train_done,
  input logic carrier_raw,
  input logic carrier_qual,
  output logic dcd,
  input logic [7:0] line_err,
  output logic retrain_resp_en,
  output logic retrain_init_en,
  output logic retrain_req,
  input logic [7:0] ring_energy,
  input logic ring_freq_ok,
  input logic cadence_ok,
  input logic opto_ring,
  output logic ring_detect,
  output logic off_hook,
  input logic cw_alert,
  input logic cid_msg_done,
  output logic dtmf_d_send,
  output logic cid_listen,
  output logic [7:0] answer_tone_en,
  input logic [7:0] rx_byte,
  input logic rx_byte_valid,
  output logic rx_in_ready,
  output logic [FIFO_W-1:0] rxd_data,
  output logic rxd_valid,
  input logic rxd_ready,
  input logic ser_idle
);
  typedef struct packed {
    mlmc_link_e link;
    mlmc_hd_e hd;
    mlmc_cid_e cid;
    logic [7:0] r_loss, r_spacing, r_rinit, r_rthr;
    logic [7:0] r_callopt, r_cid, r_country, r_ans, r_ring;
    logic hdx, fixed, raw, hup_dtr, rresp;
    mlmc_cnt_t hd_cnt, sp_cnt, loss_pre;
    logic [7:0] loss_units;
    logic cmd_ready, rvalid;
    logic [7:0] rdata;
    logic cts, txc, search, train_start, dcd, rreq;
    logic ring, dtmf_d, listen, off_hook, dtr_prev;
    logic msg;
    logic [1:0] msg_idx;
    logic pend_v;
    logic [7:0] pend_d;
    logic rx_rdy;
  } mlmc_state_s;
  mlmc_state_s s_q, s_d;

  logic cmd_take, carr_sel, dtr_tog, type2_on, path_open, hit, freq_chk;
  logic fifo_in_valid, fifo_in_ready, fifo_empty, out_done;
  logic take_rresp, take_hup;
  logic [7:0] fifo_in_data;

  assign cmd_take = cmd_valid && s_q.cmd_ready;
  assign carr_sel = s_q.raw ? carrier_raw : carrier_qual;
  assign dtr_tog = s_q.hup_dtr && (dtr != s_q.dtr_prev);
  assign type2_on = s_q.r_callopt[TYPE2_CID_BIT] && s_q.off_hook;
  assign path_open = (s_q.link == LK_DATA) || s_q.listen;
  assign freq_chk = !s_q.r_ring[RING_NOFREQ_BIT];
  // Whole register at zero falls back to the optocoupler input
  assign hit = (s_q.r_ring != 8'h00) ?
    (ring_energy >= {1'b0, s_q.r_ring[6:0]}) : opto_ring;
  assign fifo_in_valid = s_q.msg || s_q.pend_v;
  assign fifo_in_data = s_q.msg ? OK_MSG[s_q.msg_idx] : s_q.pend_d;
  assign out_done = fifo_empty && ser_idle && !s_q.msg && !s_q.pend_v;
  assign take_rresp = cmd_take && (cmd_code == CMD_RETRAIN_RESPONSE);
  assign take_hup = cmd_take && (cmd_code == CMD_HANGUP);

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.train_start = 1'b0;
    s_d.dtmf_d = 1'b0;
    s_d.dtr_prev = dtr;

    unique case (s_q.link)
      LK_IDLE: begin
      end
      LK_TRAIN: begin
        if (train_done) begin
          s_d.link = LK_DATA;
        end
      end
      LK_DATA: begin
        // Loss counting stops at the never value; carrier still clears the counters
        if (carr_sel) begin
          s_d.loss_pre = '0;
          s_d.loss_units = 8'h00;
        end else if (s_q.r_loss != LOSS_NEVER) begin
          if (s_q.loss_units >= s_q.r_loss) begin
            s_d.link = LK_IDLE;
            s_d.off_hook = 1'b0;
          end else if (s_q.loss_pre == mlmc_cnt_t'(LOSS_CYC - 1)) begin
            s_d.loss_pre = '0;
            s_d.loss_units = s_q.loss_units + 8'h01;
          end else begin
            s_d.loss_pre = s_q.loss_pre + 1'b1;
          end
        end
      end
      LK_HANGUP: begin
        // Carrier holds until the last result byte left the port
        if (out_done) begin
          s_d.link = LK_IDLE;
          s_d.off_hook = 1'b0;
        end
      end
    endcase
    if (s_d.link != LK_DATA) begin
      s_d.loss_pre = '0;
      s_d.loss_units = 8'h00;
    end

    if (dtr_tog && (s_q.link == LK_TRAIN || s_q.link == LK_DATA)) begin
      s_d.link = LK_HANGUP;
      s_d.msg = 1'b1;
      s_d.msg_idx = 2'd0;
    end

    unique case (s_q.cid)
      CID_IDLE: begin
        if (type2_on && cw_alert) begin
          s_d.cid = CID_SEND_D;
          s_d.dtmf_d = 1'b1;
        end
      end
      CID_SEND_D: begin
        s_d.cid = CID_RX;
      end
      CID_RX: begin
        if (cid_msg_done) begin
          s_d.cid = CID_IDLE;
          s_d.link = LK_IDLE;
          s_d.off_hook = 1'b0;
        end
      end
    endcase

    if (cmd_take) begin
      if (s_q.r_spacing[SPACING_BIT]) begin
        s_d.cmd_ready = 1'b0;
        s_d.sp_cnt = mlmc_cnt_t'(SPACE_CYC - 1);
      end
      case (mlmc_cmd_e'(cmd_code))
        CMD_SREG_WR: begin
          case (cmd_addr)
            REG_CARRIER_LOSS: s_d.r_loss = cmd_data;
            REG_RETRAIN_INIT: s_d.r_rinit = cmd_data;
            REG_RETRAIN_THR: s_d.r_rthr = cmd_data;
            REG_CMD_SPACING: s_d.r_spacing = cmd_data;
            REG_CALLER_ID: s_d.r_cid = cmd_data;
            REG_CALL_OPT: s_d.r_callopt = cmd_data;
            REG_ANS_TONE: s_d.r_ans = cmd_data & ANS_TONE_MASK;
            REG_RING_THR: s_d.r_ring = cmd_data;
            REG_COUNTRY: begin
              // One value loads a set; each stays writable later
              s_d.r_country = cmd_data;
              s_d.r_ans = RST_ANS;
              s_d.r_loss = RST_LOSS;
              s_d.r_spacing = RST_SPACING;
              s_d.r_ring = (cmd_data == PROF_US) ? RST_RING : PROF_OTHER_RING;
            end
            default: begin
            end
          endcase
        end
        CMD_SREG_RD: begin
          s_d.rvalid = 1'b1;
          case (cmd_addr)
            REG_CARRIER_LOSS: s_d.rdata = s_q.r_loss;
            REG_RETRAIN_INIT: s_d.rdata = s_q.r_rinit;
            REG_RETRAIN_THR: s_d.rdata = s_q.r_rthr;
            REG_CMD_SPACING: s_d.rdata = s_q.r_spacing;
            REG_CALLER_ID: s_d.rdata = s_q.r_cid;
            REG_CALL_OPT: s_d.rdata = s_q.r_callopt;
            REG_ANS_TONE: s_d.rdata = s_q.r_ans;
            REG_RING_THR: s_d.rdata = s_q.r_ring;
            REG_COUNTRY: s_d.rdata = s_q.r_country;
            default: s_d.rdata = 8'h00;
          endcase
        end
        CMD_GATED_HALF_DUPLEX: s_d.hdx = 1'b1;
        CMD_OTHER_MODULATION: s_d.hdx = 1'b0;
        CMD_FIXED_LINK_MODE: s_d.fixed = 1'b1;
        CMD_RAW_CARRIER: s_d.raw = 1'b1;
        CMD_QUALIFIED_CARRIER: s_d.raw = 1'b0;
        CMD_HANGUP_ON_TOGGLE: s_d.hup_dtr = 1'b1;
        CMD_RETRAIN_RESPONSE: s_d.rresp = 1'b1;
        CMD_DIAL, CMD_ANSWER: begin
          if (s_q.link == LK_IDLE) begin
            s_d.off_hook = 1'b1;
            s_d.link = s_q.fixed ? LK_DATA : LK_TRAIN;
            s_d.train_start = !s_q.fixed;
          end
        end
        CMD_HANGUP: begin
          s_d.link = LK_IDLE;
          s_d.off_hook = 1'b0;
          s_d.msg = 1'b0;
        end
        CMD_FACTORY: begin
          s_d.hdx = 1'b0;
          s_d.fixed = 1'b0;
          s_d.raw = 1'b0;
          s_d.hup_dtr = 1'b0;
          s_d.rresp = 1'b0;
          s_d.r_loss = RST_LOSS;
          s_d.r_spacing = RST_SPACING;
          s_d.r_rinit = RST_RETRAIN_INIT;
          s_d.r_rthr = RST_RETRAIN_THR;
          s_d.r_callopt = RST_CALL_OPT;
          s_d.r_cid = RST_CID;
          s_d.r_ans = RST_ANS;
          s_d.r_ring = RST_RING;
        end
        default: begin
        end
      endcase
    end else if (!s_q.cmd_ready) begin
      if (s_q.sp_cnt == '0) begin
        s_d.cmd_ready = 1'b1;
      end else begin
        s_d.sp_cnt = s_q.sp_cnt - 1'b1;
      end
    end
    if (!s_d.off_hook) begin
      s_d.cid = CID_IDLE;
    end

    // RTS gating runs only while a link is up
    if (s_q.hdx && (s_q.link == LK_TRAIN || s_q.link == LK_DATA)) begin
      unique case (s_q.hd)
        HD_OFF: begin
          if (rts) begin
            s_d.hd = HD_ON_DLY;
            s_d.hd_cnt = mlmc_cnt_t'(ON_CYC - 1);
          end
        end
        HD_ON_DLY: begin
          if (!rts) begin
            s_d.hd = HD_OFF;
          end else if (s_q.hd_cnt == '0) begin
            s_d.hd = HD_ON;
          end else begin
            s_d.hd_cnt = s_q.hd_cnt - 1'b1;
          end
        end
        HD_ON: begin
          if (!rts) begin
            s_d.hd = HD_OFF_DLY;
            s_d.hd_cnt = mlmc_cnt_t'(OFF_CYC - 1);
          end
        end
        HD_OFF_DLY: begin
          // RTS during the tail is seen only once the carrier is down
          if (s_q.hd_cnt == '0) begin
            s_d.hd = HD_OFF;
          end else begin
            s_d.hd_cnt = s_q.hd_cnt - 1'b1;
          end
        end
      endcase
    end else begin
      s_d.hd = HD_OFF;
    end

    unique case (s_d.link)
      LK_IDLE: s_d.txc = 1'b0;
      LK_TRAIN, LK_DATA: begin
        s_d.txc = s_q.hdx ?
          (s_d.hd == HD_ON || s_d.hd == HD_OFF_DLY) : 1'b1;
      end
      LK_HANGUP: s_d.txc = s_q.txc;
    endcase
    s_d.cts = s_q.hdx ? (s_d.hd == HD_ON) : 1'b1;
    s_d.search = (s_d.link == LK_TRAIN || s_d.link == LK_DATA) &&
      !carr_sel;
    s_d.dcd = carr_sel;
    s_d.rreq = (s_q.link == LK_DATA) && s_q.r_rinit[RETRAIN_INIT_BIT] &&
      (line_err > s_q.r_rthr);
    s_d.ring = hit && cadence_ok && (!freq_chk || ring_freq_ok);
    s_d.listen = ((s_q.r_cid == CID_SNOOP_VAL) && !s_d.off_hook) ||
      (s_d.cid == CID_RX);

    if (fifo_in_ready) begin
      if (s_q.msg) begin
        s_d.msg_idx = s_q.msg_idx + 2'd1;
        s_d.msg = (s_q.msg_idx != 2'd3) && s_d.msg;
      end else if (s_q.pend_v) begin
        s_d.pend_v = 1'b0;
      end
    end
    if (s_q.rx_rdy && rx_byte_valid) begin
      s_d.pend_v = 1'b1;
      s_d.pend_d = rx_byte;
    end
    s_d.rx_rdy = path_open && !s_d.pend_v && !s_d.msg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.link <= LK_IDLE;
      s_q.hd <= HD_OFF;
      s_q.cid <= CID_IDLE;
      s_q.r_loss <= RST_LOSS;
      s_q.r_spacing <= RST_SPACING;
      s_q.r_rinit <= RST_RETRAIN_INIT;
      s_q.r_rthr <= RST_RETRAIN_THR;
      s_q.r_callopt <= RST_CALL_OPT;
      s_q.r_cid <= RST_CID;
      s_q.r_country <= PROF_US;
      s_q.r_ans <= RST_ANS;
      s_q.r_ring <= RST_RING;
      s_q.cmd_ready <= 1'b1;
      s_q.cts <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  mlmc_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_data(fifo_in_data),
    .in_ready(fifo_in_ready),
    .out_valid(rxd_valid),
    .out_data(rxd_data),
    .out_ready(rxd_ready),
    .empty(fifo_empty)
  );

  assign cmd_ready = s_q.cmd_ready;
  assign sreg_rdata = s_q.rdata;
  assign sreg_rvalid = s_q.rvalid;
  assign cts = s_q.cts;
  assign tx_carrier = s_q.txc;
  assign search_remote = s_q.search;
  assign train_start = s_q.train_start;
  assign dcd = s_q.dcd;
  assign retrain_resp_en = s_q.rresp;
  assign retrain_init_en = s_q.r_rinit[RETRAIN_INIT_BIT];
  assign retrain_req = s_q.rreq;
  assign ring_detect = s_q.ring;
  assign off_hook = s_q.off_hook;
  assign dtmf_d_send = s_q.dtmf_d;
  assign cid_listen = s_q.listen;
  assign answer_tone_en = s_q.r_ans;
  assign rx_in_ready = s_q.rx_rdy;

  // Helper ages for the timing checks below
  mlmc_cnt_t rts_hi, off_age;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rts_hi <= '0;
      off_age <= '0;
    end else begin
      rts_hi <= !rts ? '0 : (&rts_hi ? rts_hi : rts_hi + 1'b1);
      off_age <= s_q.cts ? '0 : (&off_age ? off_age : off_age + 1'b1);
    end
  end

  sequence s_cmd_taken;
    cmd_valid && s_q.cmd_ready;
  endsequence

  property p_cts_delay;
    @(posedge clk) disable iff (rst)
      $rose(s_q.cts) && s_q.hdx |-> rts_hi >= mlmc_cnt_t'(ON_CYC);
  endproperty
  a_cts_delay: assert property (p_cts_delay)
    else $error("cts rose before carrier on delay");

  property p_cts_drop;
    @(posedge clk) disable iff (rst)
      s_q.hdx && s_q.cts && !rts |=> !s_q.cts;
  endproperty
  a_cts_drop: assert property (p_cts_drop)
    else $error("cts held after rts release");

  property p_carrier_tail;
    @(posedge clk) disable iff (rst)
      $fell(s_q.txc) && $past(s_q.hdx) && s_q.link == LK_DATA
      |-> off_age >= mlmc_cnt_t'(OFF_CYC);
  endproperty
  a_carrier_tail: assert property (p_carrier_tail)
    else $error("carrier dropped before off delay");

  property p_dcd_raw;
    @(posedge clk) disable iff (rst)
      s_q.raw |=> s_q.dcd == $past(carrier_raw);
  endproperty
  a_dcd_raw: assert property (p_dcd_raw)
    else $error("dcd does not follow raw carrier");

  property p_loss_never;
    @(posedge clk) disable iff (rst)
      s_q.link == LK_DATA && s_q.r_loss == LOSS_NEVER && !cmd_take &&
      !dtr_tog && s_q.cid == CID_IDLE |=> s_q.link == LK_DATA;
  endproperty
  a_loss_never: assert property (p_loss_never)
    else $error("link dropped with loss timeout disabled");

  property p_spacing;
    @(posedge clk) disable iff (rst)
      s_cmd_taken and s_q.r_spacing[SPACING_BIT] |=> !s_q.cmd_ready [*8];
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("command pause missing");

  property p_fixed_link;
    @(posedge clk) disable iff (rst)
      s_cmd_taken and cmd_code == CMD_DIAL && s_q.fixed &&
      s_q.link == LK_IDLE && s_q.cid == CID_IDLE
      |=> s_q.link == LK_DATA && !s_q.train_start;
  endproperty
  a_fixed_link: assert property (p_fixed_link)
    else $error("fixed link did not enter data mode");

  property p_retrain_resp;
    @(posedge clk) disable iff (rst)
      $rose(s_q.rresp) |-> $past(take_rresp);
  endproperty
  a_retrain_resp: assert property (p_retrain_resp)
    else $error("retrain response enabled without command");

  property p_ok_first;
    @(posedge clk) disable iff (rst)
      $fell(s_q.txc) && $past(s_q.link) == LK_HANGUP && !$past(take_hup)
      |-> $past(out_done);
  endproperty
  a_ok_first: assert property (p_ok_first)
    else $error("carrier stopped before result was sent");

  property p_ring_opto;
    @(posedge clk) disable iff (rst)
      s_q.r_ring == 8'h00 |=> s_q.ring ==
      ($past(opto_ring) && $past(cadence_ok) && $past(ring_freq_ok));
  endproperty
  a_ring_opto: assert property (p_ring_opto)
    else $error("optocoupler ring path wrong");

  sequence s_digit_then_rx;
    s_q.cid == CID_SEND_D ##1 s_q.cid == CID_RX;
  endsequence

  property p_dtmf_d;
    @(posedge clk) disable iff (rst)
      s_q.dtmf_d && s_q.off_hook |-> s_digit_then_rx;
  endproperty
  a_dtmf_d: assert property (p_dtmf_d)
    else $error("digit D not followed by caller id receive");

  property p_cid_hook;
    @(posedge clk) disable iff (rst)
      s_q.cid == CID_RX && cid_msg_done |=> !s_q.off_hook;
  endproperty
  a_cid_hook: assert property (p_cid_hook)
    else $error("no return on hook after caller id");
endmodule

// file: bench/mlmc_host.sv
`timescale 1ns/1ps
module mlmc_host (
  input wire logic clk,
  input wire logic key,
  input wire logic [7:0] rxd_data,
  input wire logic rxd_valid,
  output logic rxd_ready,
  output logic rts,
  output logic ser_idle
);
  logic [7:0] got [$];
  logic [1:0] ph = 2'h0;
  // Keys the carrier only; pacing left to software
  assign rts = key;
  // Slow terminal: stalls every other cycle
  assign rxd_ready = ph[0];
  assign ser_idle = !rxd_valid && ph == 2'h3;
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    if (rxd_valid && rxd_ready) begin
      got.push_back(rxd_data);
    end
  end
endmodule

// file: bench/mlmc_top_tb.sv
`timescale 1ns/1ps
module mlmc_top_tb;
  import mlmc_pkg::*;
  localparam int ON = 20;
  localparam int OFF = 10;
  logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, dtr = 1'b0, key = 1'b0;
  logic carrier_raw = 1'b0, ring_freq_ok = 1'b0, cadence_ok = 1'b0;
  logic opto_ring = 1'b0, ts = 1'b0, e;
  logic [3:0] cmd_code = 4'h0;
  logic [7:0] cmd_addr = 8'h00, cmd_data = 8'h00, ring_energy = 8'h00;
  logic [7:0] rx_byte = 8'h00, t, sreg_rdata, answer_tone_en, rxd_data;
  logic cmd_ready, sreg_rvalid, rts, cts, tx_carrier, search_remote;
  logic train_start, dcd, ring_detect, off_hook, cid_listen, rxd_valid;
  logic rxd_ready, ser_idle;
  logic retrain_resp_en, retrain_init_en, dtmf_d_send, rx_in_ready;
  logic train_done = 1'b0, cw_alert = 1'b0, cid_msg_done = 1'b0;
  logic rx_byte_valid = 1'b0;
  int n_fail = 0, num_checks = 0, cyc = 0, n;
  mlmc_top #(.ON_CYC(ON), .OFF_CYC(OFF), .SPACE_CYC(10), .LOSS_CYC(16))
    dut (.clk, .rst, .cmd_valid, .cmd_code, .cmd_addr, .cmd_data,
    .cmd_ready, .sreg_rdata, .sreg_rvalid, .rts, .cts, .dtr, .tx_carrier,
    .search_remote, .train_start, .train_done, .carrier_raw,
    .carrier_qual(1'b0), .dcd, .line_err(8'h00), .retrain_resp_en,
    .retrain_init_en, .retrain_req(), .ring_energy, .ring_freq_ok,
    .cadence_ok, .opto_ring, .ring_detect, .off_hook, .cw_alert,
    .cid_msg_done, .dtmf_d_send, .cid_listen, .answer_tone_en,
    .rx_byte, .rx_byte_valid, .rx_in_ready, .rxd_data,
    .rxd_valid, .rxd_ready, .ser_idle);
  mlmc_host host (.clk, .key, .rxd_data, .rxd_valid, .rxd_ready, .rts,
    .ser_idle);
  always #50 clk = ~clk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (train_start === 1'b1) ts <= 1'b1;
    if (cyc > 20000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Holds the request until an edge samples cmd_ready high
  task automatic cmd(input logic [3:0] c, input logic [7:0] a, d);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_addr <= a;
    cmd_data <= d;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    cmd(CMD_SREG_RD, a, 8'h00);
    chk({7'h0, sreg_rvalid}, 8'h01);
    chk(sreg_rdata, exp);
  endtask
  // Watches the live signal; a value argument would freeze it at the call
  task automatic upto(ref logic v, input logic want, input int lim);
    while (v !== want && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  function automatic logic ring_exp(input logic [7:0] t, en);
    logic hit;
    hit = (t == 8'h00) ? opto_ring : (en >= {1'b0, t[6:0]});
    return hit & cadence_ok & (ring_freq_ok | t[7]);
  endfunction
  initial begin
    void'($urandom(82));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(answer_tone_en, 8'h35);
    rd(REG_RING_THR, 8'h00);
    rd(REG_RETRAIN_INIT, 8'h00);
    chk({6'h0, retrain_resp_en, retrain_init_en}, 8'h00);
    cmd(CMD_RETRAIN_RESPONSE, 8'h00, 8'h00);
    cmd(CMD_SREG_WR, REG_RETRAIN_INIT, 8'h04);
    chk({6'h0, retrain_resp_en, retrain_init_en}, 8'h03);
    rd(8'h01, 8'h00);
    chk({7'h0, cmd_ready}, 8'h00);
    cmd(CMD_SREG_WR, REG_CMD_SPACING, 8'h00);
    rd(REG_ANS_TONE, 8'h35);
    chk({7'h0, cmd_ready}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      cmd(CMD_SREG_WR, REG_ANS_TONE, 8'h01 << i);
      rd(REG_ANS_TONE, (8'h01 << i) & 8'h37);
      chk(answer_tone_en, (8'h01 << i) & 8'h37);
    end
    cmd(CMD_SREG_WR, REG_COUNTRY, PROF_US);
    rd(REG_ANS_TONE, 8'h35);
    $display("end of register tests");
    for (int i = 0; i < 60; i++) begin
      t = 8'(129 + $urandom % 127);
      if (i % 3 == 1) t = 8'(3 + $urandom % 28);
      if (i % 3 == 0) t = 8'h00;
      cmd(CMD_SREG_WR, REG_RING_THR, t);
      {ring_freq_ok, cadence_ok, opto_ring} <= 3'($urandom);
      ring_energy <= 8'($urandom % 160);
      rx_byte <= 8'($urandom);
      repeat (2) @(posedge clk);
      e = ring_exp(t, ring_energy);
      chk({7'h0, ring_detect}, {7'h0, e});
    end
    $display("end of ring tests");
    cmd(CMD_SREG_WR, REG_CARRIER_LOSS, 8'hff);
    cmd(CMD_SREG_WR, REG_CALLER_ID, 8'h99);
    @(posedge clk);
    chk({7'h0, cid_listen}, 8'h01);
    cmd(CMD_GATED_HALF_DUPLEX, 8'h00, 8'h00);
    cmd(CMD_RAW_CARRIER, 8'h00, 8'h00);
    cmd(CMD_HANGUP_ON_TOGGLE, 8'h00, 8'h00);
    cmd(CMD_FIXED_LINK_MODE, 8'h00, 8'h00);
    cmd(CMD_DIAL, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    chk({6'h0, off_hook, search_remote}, 8'h03);
    chk({6'h0, ts, cid_listen}, 8'h00);
    carrier_raw <= 1'b1;
    repeat (2) @(posedge clk);
    chk({6'h0, dcd, search_remote}, 8'h02);
    carrier_raw <= 1'b0;
    repeat (4200) @(posedge clk);
    chk({7'h0, off_hook}, 8'h01);
    chk({7'h0, cts}, 8'h00);
    key <= 1'b1;
    n = 0;
    upto(cts, 1'b1, 100);
    chk(8'(n), 8'(ON + 2));
    chk({7'h0, tx_carrier}, 8'h01);
    key <= 1'b0;
    repeat (3) @(posedge clk);
    chk({6'h0, cts, tx_carrier}, 8'h01);
    n = 3;
    upto(tx_carrier, 1'b0, 100);
    chk({7'h0, 1'(n >= OFF + 1 && n <= OFF + 2)}, 8'h01);
    $display("end of link tests");
    // Carrier keyed up so the hang-up has a carrier to hold
    key <= 1'b1;
    n = 0;
    upto(tx_carrier, 1'b1, 100);
    dtr <= 1'b1;
    repeat (3) @(posedge clk);
    chk({6'h0, off_hook, tx_carrier}, 8'h03);
    n = 0;
    upto(off_hook, 1'b0, 400);
    key <= 1'b0;
    chk({6'h0, off_hook, tx_carrier}, 8'h00);
    chk(8'(host.got.size()), 8'h04);
    foreach (host.got[i]) chk(host.got[i], OK_MSG[i]);
    repeat (2) @(posedge clk);
    chk({7'h0, cid_listen}, 8'h01);
    t = 8'($urandom);
    rx_byte <= t;
    rx_byte_valid <= 1'b1;
    do @(posedge clk); while (rx_in_ready !== 1'b1);
    rx_byte_valid <= 1'b0;
    repeat (8) @(posedge clk);
    chk(8'(host.got.size()), 8'h05);
    chk(host.got[4], t);
    $display("end of hang-up test");
    cmd(CMD_FACTORY, 8'h00, 8'h00);
    cmd(CMD_SREG_WR, REG_CALL_OPT, 8'h08);
    cmd(CMD_ANSWER, 8'h00, 8'h00);
    @(posedge clk);
    chk({5'h0, ts, search_remote, rx_in_ready}, 8'h06);
    train_done <= 1'b1;
    repeat (3) @(posedge clk);
    train_done <= 1'b0;
    chk({7'h0, rx_in_ready}, 8'h01);
    cw_alert <= 1'b1;
    repeat (2) @(posedge clk);
    cw_alert <= 1'b0;
    chk({7'h0, dtmf_d_send}, 8'h01);
    @(posedge clk);
    chk({6'h0, cid_listen, off_hook}, 8'h03);
    cid_msg_done <= 1'b1;
    repeat (2) @(posedge clk);
    cid_msg_done <= 1'b0;
    chk({7'h0, off_hook}, 8'h00);
    $display("end of caller id test");
    complete_run();
  end
endmodule
